// *** rtl/adc_control.sv ***
// Control and result registers of a 12-bit differential converter.
// Assumes the analog core returns a signed result with a done pulse.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
// Operation
// - Negative code zero grounds negative input
// - Positive select routes channels and internals
// - Code 11100 opens all mux switches
// - Reserved input codes are not blocked
// - Start bit starts, reads busy, self-clears
// - Module-on bit enables or powers off
// - Two-bit field selects special trigger
// - Two-bit field selects positive reference
// - Bit three selects negative reference
// - Negative code maps ground, inputs 0-6
// - Format bit picks right or left
// - Acquisition field sets conversion-clock periods
// - Clock field selects divider or RC
// - RC clock starts one instruction later
// - Result loaded as sign-extended two's complement
// - Left format: high 11:4, low 3:0+signs
// - Right format: high signs plus 11:8
// - Sign copies show result sign
// - Result bytes are plain storage when off
// - Unused control bits read zero
// - Completion loads result, clears busy, flags
// - Right format low byte holds 7:0
// - Reset turns off, aborts; result unreset
module adc_control
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_LEN = 14,
	parameter logic [7:0] RC_DELAY = `RC_START_DELAY
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clkEn,
	// Register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	// Triggers and RC clock strobe
	input wire logic [3:0] specialTrig,
	input wire logic rcTick,
	// Analog core side
	input wire conv_result_t coreResult,
	output analog_route_t route,
	output logic converterOn,
	output logic sampleHold,
	output logic convRun,
	output logic convDoneFlag
);
	// ==========================================
	// Reset release
	logic rstMeta_q;
	logic rstN;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstMeta_q <= 1'b0;
			rstN <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstN <= rstMeta_q;
		end
	end
	// ==========================================
	// Control registers
	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [15:0] resPair_q;
	logic wr0;
	logic wr1;
	logic wr2;
	logic wrHi;
	logic wrLo;
	logic doneEvt;
	logic startReq;
	logic busy;
	logic onNext;
	conv_state_t state_q;
	function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
		hit = regWrStb && (a == ofs);
	endfunction : hit
	assign wr0 = hit(regAddr, `OFS_CTRL0);
	assign wr1 = hit(regAddr, `OFS_CTRL1);
	assign wr2 = hit(regAddr, `OFS_CTRL2);
	assign wrHi = hit(regAddr, `OFS_RES_HIGH);
	assign wrLo = hit(regAddr, `OFS_RES_LOW);
	assign busy = ctrl0_q[`CTRL0_GO_BIT];
	// Switch-on and start may share one write, so look at the value being written
	assign onNext = wr0 ? regWrData[`CTRL0_ON_BIT] : ctrl0_q[`CTRL0_ON_BIT];
	assign startReq = ctrl0_q[`CTRL0_ON_BIT] && state_q == ST_IDLE
		&& specialTrig[ctrl1_q[7:6]];
	assign doneEvt = state_q == ST_CONV && coreResult.done;
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			ctrl0_q <= `CTRL0_RESET;
		else if (clkEn)
		begin
			if (wr0)
				ctrl0_q <= regWrData & `CTRL0_WMASK;
			if (!ctrl0_q[`CTRL0_ON_BIT] && !(wr0 && regWrData[`CTRL0_ON_BIT]))
				ctrl0_q[`CTRL0_GO_BIT] <= 1'b0;
			else if (startReq)
				ctrl0_q[`CTRL0_GO_BIT] <= 1'b1;
			else if (doneEvt)
				ctrl0_q[`CTRL0_GO_BIT] <= 1'b0;
			if (wr0 && !regWrData[`CTRL0_ON_BIT])
				ctrl0_q[`CTRL0_GO_BIT] <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			ctrl1_q <= `CTRL1_RESET;
			ctrl2_q <= `CTRL2_RESET;
		end
		else if (clkEn)
		begin
			if (wr1)
				ctrl1_q <= regWrData;
			if (wr2)
				ctrl2_q <= regWrData & `CTRL2_WMASK;
		end
	end
	// ==========================================
	// Sequencer
	logic [7:0] cnt_q;
	logic [7:0] acqLen;
	logic tick;
	logic isRc;
	always_comb
	begin
		unique case (ctrl2_q[5:3])
			3'h0: acqLen = 8'd0;
			3'h1: acqLen = 8'd2;
			3'h2: acqLen = 8'd4;
			3'h3: acqLen = 8'd6;
			3'h4: acqLen = 8'd8;
			3'h5: acqLen = 8'd12;
			3'h6: acqLen = 8'd16;
			3'h7: acqLen = 8'd20;
		endcase
	end
	assign isRc = ctrl2_q[2:0] == `CLK_SEL_RC_A || ctrl2_q[2:0] == `CLK_SEL_RC_B;
	conv_clock_gen u_clk (
		.clk_sys(clk_sys),
		.rstN(rstN),
		.clkEn(clkEn),
		.run(state_q == ST_ACQ || state_q == ST_CONV),
		.clkSel(ctrl2_q[2:0]),
		.rcTick(rcTick),
		.tick(tick)
	);
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
		end
		else if (clkEn)
		begin
			if (!onNext)
			begin
				state_q <= ST_IDLE;
				cnt_q <= 8'h00;
			end
			else
			begin
				unique case (state_q)
					ST_IDLE:
						if ((wr0 && regWrData[`CTRL0_GO_BIT]) || startReq)
						begin
							cnt_q <= 8'h00;
							if (isRc)
								state_q <= ST_DELAY;
							else if (acqLen == 8'h00)
								state_q <= ST_CONV;
							else
								state_q <= ST_ACQ;
						end
					ST_DELAY:
						if (cnt_q == RC_DELAY - 8'h01)
						begin
							cnt_q <= 8'h00;
							state_q <= (acqLen == 8'h00) ? ST_CONV : ST_ACQ;
						end
						else
							cnt_q <= cnt_q + 8'h01;
					ST_ACQ:
						if (tick)
						begin
							if (cnt_q == acqLen - 8'h01)
							begin
								cnt_q <= 8'h00;
								state_q <= ST_CONV;
							end
							else
								cnt_q <= cnt_q + 8'h01;
						end
					ST_CONV:
						if (doneEvt)
							state_q <= ST_IDLE;
					default:
						state_q <= ST_IDLE;
				endcase
			end
		end
	end
	// ==========================================
	// Result pair, never reset; plain storage when off
	logic [15:0] formatted;
	result_formatter u_fmt (
		.value(coreResult.value),
		.rightJust(ctrl2_q[`CTRL2_FMT_BIT]),
		.pair(formatted)
	);
	always_ff @(posedge clk_sys)
	begin
		if (clkEn)
		begin
			if (doneEvt)
				resPair_q <= formatted;
			else
			begin
				if (wrHi)
					resPair_q[15:8] <= regWrData;
				if (wrLo)
					resPair_q[7:0] <= regWrData;
			end
		end
	end
	// ==========================================
	// Outputs
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
		begin
			regRdData <= 8'h00;
			route <= '0;
			// Negative code resets to zero, which means ground
			route.negGround <= 1'b1;
			converterOn <= 1'b0;
			sampleHold <= 1'b0;
			convRun <= 1'b0;
			convDoneFlag <= 1'b0;
		end
		else if (clkEn)
		begin
			unique case (regAddr)
				`OFS_CTRL0: regRdData <= regRdStb ? ctrl0_q : 8'h00;
				`OFS_CTRL1: regRdData <= regRdStb ? ctrl1_q : 8'h00;
				`OFS_CTRL2: regRdData <= regRdStb ? ctrl2_q : 8'h00;
				`OFS_RES_HIGH: regRdData <= regRdStb ? resPair_q[15:8] : 8'h00;
				`OFS_RES_LOW: regRdData <= regRdStb ? resPair_q[7:0] : 8'h00;
				default: regRdData <= 8'h00;
			endcase
			route.posSel <= ctrl0_q[6:2];
			route.openMux <= ctrl0_q[6:2] == `POS_SEL_OPEN;
			route.negSel <= ctrl1_q[2:0];
			route.negGround <= ctrl1_q[2:0] == `NEG_SEL_GROUND;
			route.posRef <= ctrl1_q[5:4];
			route.negRef <= ctrl1_q[3];
			converterOn <= ctrl0_q[`CTRL0_ON_BIT];
			sampleHold <= state_q == ST_ACQ;
			convRun <= state_q == ST_CONV;
			convDoneFlag <= doneEvt;
		end
	end
	// ==========================================
	// Checks
	a_done_clears_busy: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && doneEvt && ctrl0_q[0] && !wr0 |=> !busy)
		else $error("busy not cleared at completion");
	a_done_sets_flag: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && doneEvt |=> convDoneFlag)
		else $error("done flag missing");
	a_off_idle: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && !ctrl0_q[0] && !wr0 |=> state_q == ST_IDLE && !busy)
		else $error("activity while off");
	a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rstN)
		!ctrl0_q[7] && !ctrl2_q[6])
		else $error("unused bit set");
	a_zero_acq: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && state_q == ST_IDLE && ctrl0_q[0] && wr0 && regWrData[1] && regWrData[0]
		&& !isRc && ctrl2_q[5:3] == 3'h0 |=> state_q == ST_CONV)
		else $error("zero acquisition not immediate");
	a_rc_delay: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && state_q == ST_IDLE && ctrl0_q[0] && wr0 && regWrData[1] && regWrData[0]
		&& isRc |=> state_q == ST_DELAY)
		else $error("rc delay skipped");
	a_open_mux: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && $past(clkEn) && ctrl0_q[6:2] == $past(ctrl0_q[6:2]) |->
		route.openMux == (ctrl0_q[6:2] == 5'h1C))
		else $error("open mux decode wrong");
	a_neg_ground: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && $past(clkEn) && ctrl1_q[2:0] == $past(ctrl1_q[2:0]) |->
		route.negGround == (ctrl1_q[2:0] == 3'h0))
		else $error("ground decode wrong");
	a_result_load: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && doneEvt |=> resPair_q == $past(formatted))
		else $error("result not loaded");
	a_on_and_start: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && state_q == ST_IDLE && !ctrl0_q[0] && wr0 && regWrData[1:0] == 2'b11
		&& !isRc && acqLen == 8'h00 |=> state_q == ST_CONV && busy)
		else $error("start with switch-on lost");
	a_trig_start: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && startReq && onNext |=> busy && state_q != ST_IDLE)
		else $error("trigger did not start");
	a_fmt_right: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && doneEvt && ctrl2_q[7] |->
		formatted == {{4{coreResult.value[12]}}, coreResult.value[11:0]})
		else $error("right layout wrong");
	a_fmt_left: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && doneEvt && !ctrl2_q[7] |->
		formatted == {coreResult.value[11:0], {4{coreResult.value[12]}}})
		else $error("left layout wrong");
	a_acq_to_conv: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && state_q == ST_ACQ && tick && cnt_q == acqLen - 8'h01 && onNext
		|=> state_q == ST_CONV)
		else $error("acquisition did not end");
	a_rc_wait: assert property (@(posedge clk_sys) disable iff (!rstN)
		clkEn && state_q == ST_DELAY && cnt_q != RC_DELAY - 8'h01 && onNext
		|=> state_q == ST_DELAY)
		else $error("rc delay cut short");
	a_freeze_state: assert property (@(posedge clk_sys) disable iff (!rstN)
		!clkEn |=> $stable(ctrl0_q) && $stable(state_q) && $stable(cnt_q))
		else $error("state moved while frozen");
	c_conversion: cover property (@(posedge clk_sys) disable iff (!rstN) doneEvt);
	c_trigger: cover property (@(posedge clk_sys) disable iff (!rstN) startReq);
	c_rc_path: cover property (@(posedge clk_sys) disable iff (!rstN) state_q == ST_DELAY);
	c_acq: cover property (@(posedge clk_sys) disable iff (!rstN) state_q == ST_ACQ && tick);
endmodule : adc_control

// *** rtl/adc_ctrl_consts.svh ***
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from design files.
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ==========================================
// Register offsets
`define OFS_CTRL0 3'h0
`define OFS_CTRL1 3'h1
`define OFS_CTRL2 3'h2
`define OFS_RES_HIGH 3'h3
`define OFS_RES_LOW 3'h4
// ==========================================
// Field positions
`define CTRL0_ON_BIT 0
`define CTRL0_GO_BIT 1
`define CTRL2_FMT_BIT 7
// ==========================================
// Reset values and masks
`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00
`define CTRL2_RESET 8'h00
`define CTRL0_WMASK 8'h7F
`define CTRL2_WMASK 8'hBF
// ==========================================
// Codes
`define POS_SEL_OPEN 5'h1C
`define NEG_SEL_GROUND 3'h0
`define CLK_SEL_RC_A 3'h3
`define CLK_SEL_RC_B 3'h7
// ==========================================
// Timing
`define CONV_PERIODS 8'h0E
`define RC_START_DELAY 8'h04
`endif

// *** rtl/adc_ctrl_pkg.sv ***
// Types for the converter control block.
// Assumes no surrounding context.
package adc_ctrl_pkg;
	typedef struct packed {
		logic [4:0] posSel;
		logic [2:0] negSel;
		logic [1:0] posRef;
		logic negRef;
		logic openMux;
		logic negGround;
	} analog_route_t;
	typedef struct packed {
		logic done;
		logic [12:0] value;
	} conv_result_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_ACQ = 4'b0100,
		ST_CONV = 4'b1000
	} conv_state_t;
endpackage : adc_ctrl_pkg

// *** rtl/conv_clock_gen.sv ***
// Conversion clock tick generator from the system clock.
// Assumes rcTick comes from a synchronous dedicated RC source strobe.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module conv_clock_gen
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstN,
	input wire logic clkEn,
	// Control
	input wire logic run,
	input wire logic [2:0] clkSel,
	input wire logic rcTick,
	// Tick
	output logic tick
);
	// ==========================================
	// Divider
	logic [5:0] divCnt_q;
	logic [5:0] divLast;
	logic isRc;
	always_comb
	begin
		unique case (clkSel)
			3'h0: divLast = 6'h01;
			3'h1: divLast = 6'h07;
			3'h2: divLast = 6'h1F;
			3'h4: divLast = 6'h03;
			3'h5: divLast = 6'h0F;
			3'h6: divLast = 6'h3F;
			default: divLast = 6'h00;
		endcase
	end
	assign isRc = (clkSel == `CLK_SEL_RC_A) || (clkSel == `CLK_SEL_RC_B);
	always_ff @(posedge clk_sys or negedge rstN)
	begin
		if (!rstN)
			divCnt_q <= 6'h00;
		else if (clkEn)
			divCnt_q <= (!run || divCnt_q == divLast) ? 6'h00 : divCnt_q + 6'h01;
	end
	assign tick = run && (isRc ? rcTick : (divCnt_q == divLast));
endmodule : conv_clock_gen

// *** rtl/result_formatter.sv ***
// Places a signed 13-bit result into the 16-bit register pair.
// Assumes value is two's complement, bit 12 the sign.
`timescale 1ns/1ps
module result_formatter
	import adc_ctrl_pkg::*;
(
	// Input
	input wire logic [12:0] value,
	input wire logic rightJust,
	// Output
	output logic [15:0] pair
);
	logic [3:0] signs;
	assign signs = {4{value[12]}};
	// Sign copies fill bits 15:12 in the right layout and bits 3:0 in the left layout
	assign pair = rightJust ? {signs, value[11:0]}
		: {value[11:0], signs};
endmodule : result_formatter

// *** verification/adc_core_model.sv ***
// Behavioural analog core: answers each conversion with a done pulse.
// Assumes convRun from the control block and one system clock.
`timescale 1ns/1ps
module adc_core_model
	import adc_ctrl_pkg::*;
#(
	parameter int DELAY = 6
)
(
	// Clock
	input wire logic clk_sys,
	// Control side
	input wire logic convRun,
	input wire logic [12:0] resVal,
	// Result
	output conv_result_t coreResult
);
	int cnt = 0;
	logic done = 1'b0;
	// ==========================================
	// Conversion timing
	// An abort clears the count, so no stale pulse lands later
	always @(posedge clk_sys)
	begin
		done <= 1'b0;
		if (!convRun)
			cnt <= 0;
		else if (cnt < DELAY)
			cnt <= cnt + 1;
		else if (cnt == DELAY)
		begin
			done <= 1'b1;
			cnt <= cnt + 1;
		end
	end
	// Value is held only in the done cycle, inverted otherwise
	assign coreResult = '{done: done, value: done ? resVal : ~resVal};
endmodule : adc_core_model

// *** verification/tb_top.sv ***
// Self-checking bench for the converter control block.
// Assumes the core model on the far side and a 25 MHz system clock.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module tb_top
	import adc_ctrl_pkg::*;
;
	typedef struct {logic [12:0] v; logic fmt; logic [7:0] hi; logic [7:0] lo;} row_t;
	row_t rows [6] = '{'{13'h0FFF, 1'b0, 8'hFF, 8'hF0}, '{13'h0FFF, 1'b1, 8'h0F, 8'hFF},
		'{13'h1FFE, 1'b0, 8'hFF, 8'hEF}, '{13'h1FFE, 1'b1, 8'hFF, 8'hFE},
		'{13'h1000, 1'b0, 8'h00, 8'h0F}, '{13'h1001, 1'b1, 8'hF0, 8'h01}};
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic [7:0] regRdData;
	logic [3:0] specialTrig = 4'h0;
	logic rcTick = 1'b0;
	logic clkEn = 1'b1;
	logic [1:0] rcDiv = 2'h0;
	logic [12:0] resVal = 13'h0000;
	conv_result_t coreResult;
	analog_route_t route;
	logic converterOn, sampleHold, convRun, convDoneFlag;
	logic [7:0] rdv;
	int bad_count = 0;
	int cmp_count = 0;
	int shCount = 0;
	int runCount = 0;
	// ==========================================
	// Clocks and instances
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		rcDiv <= rcDiv + 2'h1;
		rcTick <= (rcDiv == 2'h3);
	end
	adc_control u_adc_control (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData), .specialTrig(specialTrig),
		.rcTick(rcTick), .coreResult(coreResult), .route(route),
		.converterOn(converterOn), .sampleHold(sampleHold), .convRun(convRun),
		.convDoneFlag(convDoneFlag));
	adc_core_model u_adc_core_model (.clk_sys(clk_sys), .convRun(convRun),
		.resVal(resVal), .coreResult(coreResult));
	// ==========================================
	// Tasks
	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : chk
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk_sys);
		regWrStb <= 1'b0;
	endtask : wr
	task rc(input logic [2:0] a, input logic [7:0] e, input string n);
		@(posedge clk_sys);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
		#1;
		rdv = regRdData;
		chk(n, e, rdv);
	endtask : rc
	task trig(input int t);
		@(posedge clk_sys);
		specialTrig <= 4'h1 << t;
		@(posedge clk_sys);
		specialTrig <= 4'h0;
	endtask : trig
	// Bounded wait; the idle gap after it keeps software spacing between runs
	task waitDone;
		int i;
		shCount = 0;
		runCount = 0;
		for (i = 0; i < 400; i++)
		begin
			@(posedge clk_sys);
			#1;
			if (sampleHold === 1'b1)
				shCount++;
			if (convRun === 1'b1)
				runCount++;
			if (convDoneFlag === 1'b1)
				break;
		end
		if (i == 400)
		begin
			$display("BAD done flag expected 1 seen none");
			bad_count++;
			end_of_test();
		end
		repeat (8) @(posedge clk_sys);
	endtask : waitDone
	// ==========================================
	// Sequence
	initial
	begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		foreach (rows[i])
		begin
			wr(`OFS_CTRL2, {rows[i].fmt, 7'h00});
			resVal = rows[i].v;
			wr(`OFS_CTRL0, 8'h03);
			waitDone();
			chk("acq zero", 8'h00, shCount[7:0]);
			chk("conv run", 8'h01, {7'h00, runCount != 0});
			rc(`OFS_RES_HIGH, rows[i].hi, "res high");
			rc(`OFS_RES_LOW, rows[i].lo, "res low");
			rc(`OFS_CTRL0, 8'h01, "busy clear");
		end
		wr(`OFS_CTRL0, 8'h00);
		wr(`OFS_RES_HIGH, 8'hA5);
		wr(`OFS_RES_LOW, 8'h5A);
		rc(`OFS_RES_HIGH, 8'hA5, "store high");
		rc(`OFS_RES_LOW, 8'h5A, "store low");
		wr(`OFS_CTRL0, 8'h82);
		rc(`OFS_CTRL0, 8'h00, "start while off");
		chk("converter on", 8'h00, {7'h00, converterOn});
		wr(`OFS_CTRL2, 8'hFF);
		rc(`OFS_CTRL2, 8'hBF, "ctrl2 unused");
		rc(3'h5, 8'h00, "unmapped");
		wr(`OFS_CTRL1, 8'hEB);
		wr(`OFS_CTRL0, 8'h70);
		@(posedge clk_sys);
		#1;
		chk("refs", 8'h56, {1'b0, route.posRef, route.negRef, route.negSel, route.negGround});
		chk("mux open", 8'h39, {2'h0, route.posSel, route.openMux});
		wr(`OFS_CTRL1, 8'h00);
		wr(`OFS_CTRL0, 8'h2C);
		@(posedge clk_sys);
		#1;
		chk("ground", 8'h2D, {1'b0, route.posSel, route.openMux, route.negGround});
		wr(`OFS_CTRL2, 8'h00);
		wr(`OFS_CTRL0, 8'h01);
		for (int t = 0; t < 4; t++)
		begin
			wr(`OFS_CTRL1, {t[1:0], 6'h00});
			trig((t + 1) % 4);
			rc(`OFS_CTRL0, 8'h01, "other trigger");
			trig(t);
			rc(`OFS_CTRL0, 8'h03, "trigger busy");
			waitDone();
		end
		foreach (rows[i])
		begin
			if (i < 2)
			begin
				wr(`OFS_CTRL2, i ? 8'h0B : 8'h08);
				wr(`OFS_CTRL0, 8'h03);
				waitDone();
				if (i == 0)
					chk("acq len", 8'h04, shCount[7:0]);
				else
					chk("acq run", 8'h01, {7'h00, shCount != 0});
			end
		end
		wr(`OFS_CTRL2, 8'h3E);
		wr(`OFS_CTRL0, 8'h03);
		repeat (5) @(posedge clk_sys);
		wr(`OFS_CTRL0, 8'h00);
		rc(`OFS_CTRL0, 8'h00, "abort");
		chk("abort hold", 8'h00, {6'h00, sampleHold, convRun});
		// A write while the enable is low must leave the register as it was
		@(posedge clk_sys);
		clkEn <= 1'b0;
		wr(`OFS_CTRL1, 8'h55);
		@(posedge clk_sys);
		clkEn <= 1'b1;
		rc(`OFS_CTRL1, 8'hC0, "frozen ctrl1");
		wr(`OFS_CTRL2, 8'h00);
		wr(`OFS_CTRL0, 8'h03);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("reset outs", 8'h00, {6'h00, converterOn, convRun});
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rc(`OFS_CTRL0, 8'h00, "ctrl0 reset");
		rc(`OFS_CTRL1, 8'h00, "ctrl1 reset");
		rc(`OFS_CTRL2, 8'h00, "ctrl2 reset");
		end_of_test();
	end
endmodule : tb_top
